//--- dv/fpw_checker.sv
// port-level assertions for the four-channel pwm block, bound to its top
module fpw_checker (
   input wire logic                       ref_clk,
   input wire logic                       rst,
   input wire logic                       special_mode_flag,
   input wire logic [fpw_pkg::ADDR_W-1:0] paddr,
   input wire logic                       psel,
   input wire logic                       penable,
   input wire logic                       pwrite,
   input wire logic [31:0]                pwdata,
   input wire logic [31:0]                prdata,
   input wire logic                       pready,
   input wire logic                       pslverr,
   input wire logic [3:0]                 pwm_pin_out,
   input wire logic [3:0]                 pwm_pin_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   logic acc;
   logic wacc;
   assign acc  = psel && penable;
   assign wacc = psel && penable && pwrite;

   a_ready_follows: assert property (pready == acc)
      else $error("pready does not follow psel and penable");
   a_err_in_access: assert property (pslverr |-> acc)
      else $error("pslverr outside an access phase");
   a_err_high_addr: assert property ((psel && !penable && !pwrite && paddr[11:9] != 3'h0) ##1 acc
      |-> pslverr && prdata == 32'h00000000)
      else $error("out-of-range read not refused");
   a_err_mapped: assert property (acc && paddr[11:9] == 3'h0 && paddr[8:2] >= fpw_pkg::IDX_CLK
      && paddr[8:2] <= fpw_pkg::IDX_PDIR |-> !pslverr)
      else $error("mapped register refused");
   a_rdata_byte: assert property (prdata[31:8] == 24'h000000)
      else $error("read data upper bits not zero");
   a_reset_clears: assert property ($fell(rst) |-> pwm_pin_oe == 4'h0 && pwm_pin_out == 4'h0)
      else $error("pins not idle after reset");
   a_enable_drives: assert property (wacc && paddr[11:2] == {3'h0, fpw_pkg::IDX_EN}
      |=> (pwm_pin_oe & $past(pwdata[3:0])) == $past(pwdata[3:0]))
      else $error("enabled channel pin not driven");
   a_oe_cause: assert property (!$stable(pwm_pin_oe) |-> $past(wacc))
      else $error("pin direction changed without a write");
   a_test_normal: assert property (!special_mode_flag ##1 (!special_mode_flag && psel && !penable
      && !pwrite && paddr[11:2] == {3'h0, fpw_pkg::IDX_TST}) |=> prdata == 32'h00000000)
      else $error("test bits visible outside special mode");
endmodule // fpw_checker

bind fpw_top fpw_checker u_fpw_checker (
   .ref_clk(ref_clk), .rst(rst), .special_mode_flag(special_mode_flag), .paddr(paddr),
   .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .pwm_pin_out(pwm_pin_out), .pwm_pin_oe(pwm_pin_oe)
);

//--- dv/fpw_pin_load.sv
// load on port pins 3..0: resolves each pin level and counts its high samples
module fpw_pin_load (
   input  wire logic             ref_clk,
   input  wire logic [3:0]       pin_out,
   input  wire logic [3:0]       pin_oe,
   input  wire logic             meas_clr,
   output logic      [3:0]       pin_level,
   output logic      [3:0][15:0] high_cnt
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] last_r = 4'h0;
   // no pull-up is fitted, so an undriven pin wanders; a missing enable shows as half duty
   always_comb begin
      for (int i = 0; i < 4; i++) pin_level[i] = pin_oe[i] ? pin_out[i] : ~last_r[i];
   end
   always_ff @(posedge ref_clk) begin
      last_r <= pin_level;
      for (int i = 0; i < 4; i++) begin
         if (meas_clr) high_cnt[i] <= 16'h0000;
         else if (pin_level[i] === 1'b1) high_cnt[i] <= high_cnt[i] + 16'h0001;
      end
   end
endmodule // fpw_pin_load

//--- dv/testbench.sv
// self-checking bench for the four-channel pwm block
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic                       ref_clk;
   logic                       rst;
   logic                       special_mode_flag;
   logic [fpw_pkg::ADDR_W-1:0] paddr;
   logic                       psel, penable, pwrite, pready, pslverr, meas_clr, rerr;
   logic [31:0]                pwdata, prdata, rdat, v, v2;
   logic [3:0]                 pwm_pin_out, pwm_pin_oe, pin_level;
   logic [3:0][15:0]           high_cnt;
   int                         n_fail;
   int                         tests_run;

   fpw_top uut (.ref_clk(ref_clk), .rst(rst), .special_mode_flag(special_mode_flag),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .pwm_pin_out(pwm_pin_out),
      .pwm_pin_oe(pwm_pin_oe));
   fpw_pin_load u_load (.ref_clk(ref_clk), .pin_out(pwm_pin_out), .pin_oe(pwm_pin_oe),
      .meas_clr(meas_clr), .pin_level(pin_level), .high_cnt(high_cnt));

   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // called just after a rising edge; returns just after one
   task automatic xfer(input logic wr_en, input logic [11:0] a, input logic [7:0] d);
      int n;
      n = 0;
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr_en;
      paddr   <= a;
      pwdata  <= {24'h000000, d};
      @(posedge ref_clk);
      penable <= 1'b1;
      @(posedge ref_clk);
      while (pready !== 1'b1 && n < 40) begin
         @(posedge ref_clk);
         n++;
      end
      if (n == 40) n_fail++;
      rdat = prdata;
      rerr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic wr(input logic [6:0] idx, input logic [7:0] d);
      xfer(1'b1, {3'h0, idx, 2'h0}, d);
   endtask
   task automatic rd(input logic [6:0] idx, input logic [31:0] exp);
      xfer(1'b0, {3'h0, idx, 2'h0}, 8'h00);
      chk(rdat, exp);
   endtask
   // program one channel, start it, let it settle for win cycles, count high samples
   task automatic run(input logic [1:0] ch, input logic [3:0] en, input logic [1:0] pin,
      input logic [7:0] clk, input logic [7:0] pol, input logic [7:0] ctl, input logic [7:0] per,
      input logic [7:0] dty, input int win, input logic [15:0] exp);
      wr(fpw_pkg::IDX_EN, 8'h00);
      wr(fpw_pkg::IDX_CLK, clk);
      wr(fpw_pkg::IDX_POL, pol);
      wr(fpw_pkg::IDX_CTL, ctl);
      wr(fpw_pkg::IDX_PER0 + 7'(ch), per);
      wr(fpw_pkg::IDX_DTY0 + 7'(ch), dty);
      wr(fpw_pkg::IDX_CNT0 + 7'(ch), 8'h00);
      wr(fpw_pkg::IDX_EN, {4'h0, en});
      repeat (win) @(posedge ref_clk);
      meas_clr <= 1'b1;
      @(posedge ref_clk);
      meas_clr <= 1'b0;
      repeat (win) @(posedge ref_clk);
      #1;
      chk({16'h0000, high_cnt[pin]}, {16'h0000, exp});
      @(posedge ref_clk);
   endtask
   // clears the high byte of a joined pair before it is started
   task automatic jprep(input logic [1:0] hi);
      wr(fpw_pkg::IDX_EN, 8'h00);
      wr(fpw_pkg::IDX_PER0 + 7'(hi), 8'h00);
      wr(fpw_pkg::IDX_DTY0 + 7'(hi), 8'h00);
      wr(fpw_pkg::IDX_CNT0 + 7'(hi), 8'h00);
   endtask
   task automatic done(input string s);
      $display("test %s finished", s);
   endtask
   task automatic summarize();
      $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge ref_clk);
      n_fail++;
      summarize();
   end

   initial begin
      n_fail = 0;
      tests_run = 0;
      rst = 1'b1;
      special_mode_flag = 1'b0;
      paddr = '0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      pwdata = 32'h00000000;
      meas_clr = 1'b0;
      repeat (8) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      for (int i = 0; i < 24; i++) rd(7'h40 + 7'(i), 32'h00000000);
      chk({28'h0000000, pwm_pin_oe}, 32'h00000000);
      done("reset");
      xfer(1'b0, {3'h1, fpw_pkg::IDX_EN, 2'h0}, 8'h00);
      chk({31'h0, rerr}, 32'h00000001);
      xfer(1'b0, {3'h0, 7'h3F, 2'h0}, 8'h00);
      chk({31'h0, rerr}, 32'h00000001);
      done("bus");
      wr(fpw_pkg::IDX_PDIR, 8'h02);
      wr(fpw_pkg::IDX_EN, 8'h01);
      chk({28'h0000000, pwm_pin_oe}, 32'h00000003);
      rd(fpw_pkg::IDX_PDIR, 32'h00000002);
      wr(fpw_pkg::IDX_EN, 8'h00);
      chk({28'h0000000, pwm_pin_oe}, 32'h00000002);
      wr(fpw_pkg::IDX_PDIR, 8'h00);
      done("pins");
      wr(fpw_pkg::IDX_SCAL0, 8'h01);
      wr(fpw_pkg::IDX_SCAL1, 8'h00);
      run(2'd0, 4'h1, 2'd0, 8'h00, 8'h01, 8'h00, 8'h04, 8'h01, 50, 16'h0014);
      run(2'd0, 4'h1, 2'd0, 8'h00, 8'h00, 8'h00, 8'h04, 8'h01, 50, 16'h001E);
      run(2'd0, 4'h1, 2'd0, 8'h10, 8'h01, 8'h00, 8'h04, 8'h01, 200, 16'h0050);
      run(2'd2, 4'h4, 2'd2, 8'h01, 8'h04, 8'h00, 8'h04, 8'h01, 100, 16'h0028);
      run(2'd1, 4'h2, 2'd1, 8'h00, 8'h22, 8'h00, 8'h04, 8'h01, 200, 16'h0050);
      run(2'd3, 4'h8, 2'd3, 8'h00, 8'h88, 8'h00, 8'h04, 8'h01, 100, 16'h0028);
      run(2'd0, 4'h1, 2'd0, 8'h00, 8'h01, 8'h08, 8'h04, 8'h01, 80, 16'h0014);
      run(2'd0, 4'h1, 2'd0, 8'h00, 8'h00, 8'h08, 8'h04, 8'h01, 80, 16'h003C);
      jprep(2'd0);
      run(2'd1, 4'h1, 2'd0, 8'h40, 8'h03, 8'h00, 8'h09, 8'h04, 100, 16'h0032);
      jprep(2'd2);
      run(2'd3, 4'h4, 2'd2, 8'h80, 8'h0C, 8'h00, 8'h09, 8'h04, 100, 16'h0032);
      done("waveforms");
      wr(fpw_pkg::IDX_EN, 8'h00);
      wr(fpw_pkg::IDX_PER0, 8'hC8);
      wr(fpw_pkg::IDX_CNT0, 8'h00);
      wr(fpw_pkg::IDX_EN, 8'h01);
      wr(fpw_pkg::IDX_EN, 8'h00);
      xfer(1'b0, {3'h0, fpw_pkg::IDX_CNT0, 2'h0}, 8'h00);
      v = rdat;
      chk({31'h0, v != 32'h00000000}, 32'h00000001);
      rd(fpw_pkg::IDX_CNT0, v);
      wr(fpw_pkg::IDX_EN, 8'h01);
      wr(fpw_pkg::IDX_EN, 8'h00);
      xfer(1'b0, {3'h0, fpw_pkg::IDX_CNT0, 2'h0}, 8'h00);
      v2 = rdat;
      chk({31'h0, v2 > v}, 32'h00000001);
      special_mode_flag <= 1'b1;
      wr(fpw_pkg::IDX_TST, 8'h20);
      wr(fpw_pkg::IDX_CNT0, 8'h00);
      rd(fpw_pkg::IDX_CNT0, v2);
      wr(fpw_pkg::IDX_TST, 8'h00);
      wr(fpw_pkg::IDX_CNT0, 8'h00);
      rd(fpw_pkg::IDX_CNT0, 32'h00000000);
      wr(fpw_pkg::IDX_TST, 8'h10);
      wr(fpw_pkg::IDX_PER0, 8'h02);
      wr(fpw_pkg::IDX_EN, 8'h01);
      wr(fpw_pkg::IDX_EN, 8'h00);
      rd(fpw_pkg::IDX_CNT0, 32'h00000003);
      wr(fpw_pkg::IDX_PRES, 8'h15);
      rd(fpw_pkg::IDX_PRES, 32'h00000015);
      wr(fpw_pkg::IDX_SCAL0, 8'h05);
      rd(fpw_pkg::IDX_SCNT0, 32'h00000005);
      wr(fpw_pkg::IDX_TST, 8'h08);
      wr(fpw_pkg::IDX_SCAL0, 8'h01);
      rd(fpw_pkg::IDX_SCNT0, 32'h00000005);
      special_mode_flag <= 1'b0;
      wr(fpw_pkg::IDX_PRES, 8'h2A);
      rd(fpw_pkg::IDX_PRES, 32'h00000015);
      rd(fpw_pkg::IDX_TST, 32'h00000000);
      done("counters");
      wr(fpw_pkg::IDX_EN, 8'h05);
      rst <= 1'b1;
      repeat (4) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      rd(fpw_pkg::IDX_EN, 32'h00000000);
      rd(fpw_pkg::IDX_CLK, 32'h00000000);
      done("rereset");
      summarize();
   end
endmodule // testbench

//--- rtl/fpw_pkg.sv
// constants, register indices and state layout of the four-channel pwm block
package fpw_pkg;

   // register indices; byte address is four times the index
   localparam logic [6:0] IDX_CLK   = 7'h40;
   localparam logic [6:0] IDX_POL   = 7'h41;
   localparam logic [6:0] IDX_EN    = 7'h42;
   localparam logic [6:0] IDX_PRES  = 7'h43;
   localparam logic [6:0] IDX_SCAL0 = 7'h44;
   localparam logic [6:0] IDX_SCNT0 = 7'h45;
   localparam logic [6:0] IDX_SCAL1 = 7'h46;
   localparam logic [6:0] IDX_SCNT1 = 7'h47;
   localparam logic [6:0] IDX_CNT0  = 7'h48;
   localparam logic [6:0] IDX_PER0  = 7'h4C;
   localparam logic [6:0] IDX_DTY0  = 7'h50;
   localparam logic [6:0] IDX_CTL   = 7'h54;
   localparam logic [6:0] IDX_TST   = 7'h55;
   localparam logic [6:0] IDX_PDAT  = 7'h56;
   localparam logic [6:0] IDX_PDIR  = 7'h57;

   localparam int         ADDR_W    = 12;
   localparam int         IDX_LSB   = 2;
   localparam int         IDX_MSB   = 8;

   // clocks_and_concatenate fields
   localparam int         JOIN_HI_BIT = 7;
   localparam int         JOIN_LO_BIT = 6;
   localparam int         CLK_A_LSB   = 3;
   localparam int         CLK_B_LSB   = 0;
   // clock_select_and_polarity fields
   localparam int         SEL_LSB     = 4;
   localparam int         POL_LSB     = 0;
   // general_control_register and test_mode_register fields
   localparam int         CENTER_BIT  = 3;
   localparam int         CRD_BIT     = 5;
   localparam int         PCD_BIT     = 4;
   localparam int         SLD_BIT     = 3;
   localparam logic [7:0] TST_MASK    = 8'h38;

   localparam logic [7:0]  BYTE_ZERO = 8'h00;
   localparam logic [7:0]  ONE8      = 8'h01;
   localparam logic [15:0] ZERO16    = 16'h0000;
   localparam logic [15:0] ONE16     = 16'h0001;
   localparam logic [15:0] MAX8      = 16'h00FF;
   localparam logic [15:0] MAX16     = 16'hFFFF;
   localparam logic [6:0]  PRES_ONE  = 7'h01;

   typedef struct packed {
      logic [7:0]      clk_cfg;
      logic [7:0]      pol_cfg;
      logic [7:0]      en;
      logic [7:0]      ctl;
      logic [7:0]      tst;
      logic [7:0]      pdat;
      logic [7:0]      pdir;
      logic [6:0]      pres;
      logic [1:0][7:0] scal;
      logic [1:0][7:0] scnt;
      logic [1:0]      shalf;
      logic [3:0][7:0] cnt;
      logic [3:0][7:0] per_buf;
      logic [3:0][7:0] dty_buf;
      logic [3:0][7:0] per_act;
      logic [3:0][7:0] dty_act;
      logic [3:0]      dn;
      logic [3:0]      out;
      logic [3:0]      live;
      logic [31:0]     prdata;
      logic            pslverr;
   } fpw_state_t;

endpackage

//--- rtl/fpw_top.sv
// four-channel pwm with prescaler, scalers, concatenation and apb register access
// Operation
// (RULE1) join_upper_pair set: channels 2,3 form one 16-bit channel on pin 2, ch3 clock
// (RULE2) join_lower_pair set: channels 0,1 form one 16-bit channel on pin 0, ch1 clock
// (RULE3) each 3-bit prescale field divides E by two to the field value
// (RULE4) clock select bit clear picks A or B, set picks scaled clock
// (RULE5) polarity set: high at period start, low at duty; clear: the reverse
// (RULE6) duty counts low time for polarity clear left-aligned, else high time; the code counts low time for polarity clear center-aligned too
// (RULE7) enabled channel forces its pin to output without touching direction bit
// (RULE8) enable gates clock on clock edges; prescaler stops with all channels off
// (RULE9) waveform reaches pin at the selected clock's next cycle after enable
// (RULE10) prescale counter free-runs, 7 bits, readable always, writable in special mode
// (RULE11) scale write loads its down-counter unless special mode with load disable
// (RULE12) S0 is clock A divided by scale plus one, then halved
// (RULE13) S1 is clock B divided by second scale plus one, then halved
// (RULE14) scale counters count down, reload at zero, always readable
// (RULE15) channel counter write clears count and latches duty and period
// (RULE16) special mode with counter reset disable: counter write keeps count
// (RULE17) counter read returns count without disturbing the channel
// (RULE18) left-aligned period match resets counter and starts new period
// (RULE19) center-aligned counters count up and down, reversing on period match
// (RULE20) duty match toggles the output within the period
// (RULE21) enabled channel resumes from its stored count on its selected clock
// (RULE22) special mode period compare disable: left-aligned match keeps counting
// (RULE23) enabled channel buffers period and duty until rollover; disabled passes through
// (RULE24) center_align_sel clear gives left-aligned, set gives center-aligned, all channels
// (RULE25) left period is clock times (period plus one); center is clock times period times two
// (RULE26) everything clears on reset: channels disabled, left-aligned
//
// Implementation choice: register access over APB.
module fpw_top (
   input  wire logic                      ref_clk,
   input  wire logic                      rst,
   input  wire logic                      special_mode_flag,
   input  wire logic [fpw_pkg::ADDR_W-1:0] paddr,
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [31:0]               pwdata,
   output logic      [31:0]               prdata,
   output logic                           pready,
   output logic                           pslverr,
   output logic      [3:0]                pwm_pin_out,
   output logic      [3:0]                pwm_pin_oe
);

   fpw_pkg::fpw_state_t s;
   fpw_pkg::fpw_state_t n;

   logic [6:0]  idx;
   logic        mapped;
   logic [7:0]  rd;
   logic [7:0]  wd;
   logic        wr;
   logic        setup;
   logic        run;
   logic [6:0]  mask_a;
   logic [6:0]  mask_b;
   logic [1:0]  base_tick;
   logic [1:0]  sc_tick;
   logic [3:0]  ch_tick;
   logic        joined;
   logic [1:0]  lo;
   logic [15:0] c16;
   logic [15:0] p16;
   logic [15:0] d16;
   logic [15:0] mx;
   logic [15:0] nx;
   logic        ndn;
   logic        roll;
   logic        center;
   logic        pcd;

   // output level from count, period and duty, boundary cases first
   function automatic logic level(input logic [15:0] c, input logic [15:0] p,
                                  input logic [15:0] d, input logic [15:0] m,
                                  input logic pol, input logic ctr, input logic dn);
      logic v;
      v = pol;
      if (p == fpw_pkg::ZERO16) begin
         v = pol;
      end else if (d == m) begin
         v = ~pol;
      end else if (d >= p) begin
         v = pol;
      end else if (ctr) begin
         // the up-slope match counts too, so the active time is twice the duty
         v = ((c < d) || ((c == d) && !dn)) ? pol : ~pol;
      end else begin
         v = (c <= d) ? pol : ~pol;
      end
      return v;
   endfunction

   always_comb begin
      n         = s;
      idx       = paddr[fpw_pkg::IDX_MSB:fpw_pkg::IDX_LSB];
      wd        = pwdata[7:0];
      setup     = psel & ~penable;
      rd        = fpw_pkg::BYTE_ZERO;
      mapped    = (paddr[fpw_pkg::ADDR_W-1:fpw_pkg::IDX_MSB+1] == '0);
      center    = s.ctl[fpw_pkg::CENTER_BIT];                                  // (RULE24)
      pcd       = special_mode_flag & s.tst[fpw_pkg::PCD_BIT];
      joined    = 1'b0;
      lo        = 2'b00;
      c16       = fpw_pkg::ZERO16;
      p16       = fpw_pkg::ZERO16;
      d16       = fpw_pkg::ZERO16;
      mx        = fpw_pkg::MAX8;
      nx        = fpw_pkg::ZERO16;
      ndn       = 1'b0;
      roll      = 1'b0;
      base_tick = 2'b00;
      sc_tick   = 2'b00;
      ch_tick   = 4'h0;

      // read mux; counters are only sampled, never touched by a read
      case (idx)
         fpw_pkg::IDX_CLK:   rd = s.clk_cfg;
         fpw_pkg::IDX_POL:   rd = s.pol_cfg;
         fpw_pkg::IDX_EN:    rd = s.en;
         fpw_pkg::IDX_PRES:  rd = {1'b0, s.pres};                             // (RULE10)
         fpw_pkg::IDX_SCAL0: rd = s.scal[0];
         fpw_pkg::IDX_SCNT0: rd = s.scnt[0];                                  // (RULE14)
         fpw_pkg::IDX_SCAL1: rd = s.scal[1];
         fpw_pkg::IDX_SCNT1: rd = s.scnt[1];                                  // (RULE14)
         fpw_pkg::IDX_CTL:   rd = s.ctl;
         fpw_pkg::IDX_TST:   rd = s.tst;
         fpw_pkg::IDX_PDAT:  rd = s.pdat;
         fpw_pkg::IDX_PDIR:  rd = s.pdir;
         default: begin
            if (idx[6:2] == fpw_pkg::IDX_CNT0[6:2]) begin
               rd = s.cnt[idx[1:0]];                                          // (RULE17)
            end else if (idx[6:2] == fpw_pkg::IDX_PER0[6:2]) begin
               rd = s.per_buf[idx[1:0]];
            end else if (idx[6:2] == fpw_pkg::IDX_DTY0[6:2]) begin
               rd = s.dty_buf[idx[1:0]];
            end else begin
               mapped = 1'b0;
            end
         end
      endcase
      wr = psel & penable & pwrite & mapped;

      if (setup) begin
         n.prdata  = mapped ? {24'h000000, rd} : 32'h00000000;
         n.pslverr = ~mapped;
      end

      // prescaler stops while every channel is off to save power
      run = |s.en[3:0];                                                       // (RULE8)
      if (run) begin
         n.pres = s.pres + fpw_pkg::PRES_ONE;                                 // (RULE10)
      end
      mask_a = 7'((8'h01 << s.clk_cfg[fpw_pkg::CLK_A_LSB +: 3]) - 8'h01);    // (RULE3)
      mask_b = 7'((8'h01 << s.clk_cfg[fpw_pkg::CLK_B_LSB +: 3]) - 8'h01);    // (RULE3)
      base_tick[0] = run & ((s.pres & mask_a) == mask_a);
      base_tick[1] = run & ((s.pres & mask_b) == mask_b);

      // scaler: divide by scale plus one, then a toggle halves it
      for (int k = 0; k < 2; k++) begin
         if (base_tick[k]) begin
            if (s.scnt[k] == fpw_pkg::BYTE_ZERO) begin
               n.scnt[k]  = s.scal[k];                                        // (RULE14)
               n.shalf[k] = ~s.shalf[k];                                      // (RULE12) (RULE13)
               sc_tick[k] = s.shalf[k];
            end else begin
               n.scnt[k] = s.scnt[k] - fpw_pkg::ONE8;                         // (RULE14)
            end
         end
      end

      for (int i = 0; i < 4; i++) begin
         // channels 0,1 use A/S0 and 2,3 use B/S1
         ch_tick[i] = s.pol_cfg[fpw_pkg::SEL_LSB + i] ? sc_tick[i/2]          // (RULE4)
                                                       : base_tick[i/2];
      end

      for (int u = 0; u < 4; u++) begin
         joined = (u < 2) ? s.clk_cfg[fpw_pkg::JOIN_LO_BIT]                   // (RULE2)
                          : s.clk_cfg[fpw_pkg::JOIN_HI_BIT];                  // (RULE1)
         lo     = joined ? 2'(u | 1) : 2'(u);
         roll   = 1'b0;
         if (joined && (u % 2 == 1)) begin
            // low byte of a joined pair: its pin stays with the port
            n.live[u] = 1'b0;
            n.out[u]  = 1'b0;
         end else begin
            mx  = joined ? fpw_pkg::MAX16 : fpw_pkg::MAX8;
            c16 = joined ? {s.cnt[u], s.cnt[lo]} : {8'h00, s.cnt[u]};         // (RULE1) (RULE2)
            p16 = joined ? {s.per_act[u], s.per_act[lo]} : {8'h00, s.per_act[u]};
            d16 = joined ? {s.dty_act[u], s.dty_act[lo]} : {8'h00, s.dty_act[u]};
            nx  = c16;
            ndn = s.dn[u];
            if (!s.en[u]) begin
               n.live[u]    = 1'b0;
               n.per_act[u] = s.per_buf[u];                                   // (RULE23)
               n.dty_act[u] = s.dty_buf[u];
               n.per_act[lo] = s.per_buf[lo];
               n.dty_act[lo] = s.dty_buf[lo];
            end else if (ch_tick[lo]) begin
               // first tick after enable puts the waveform on the pin
               n.live[u] = 1'b1;                                              // (RULE9) (RULE21)
               if (!center) begin
                  if ((c16 == p16) && !pcd) begin                             // (RULE22)
                     nx   = fpw_pkg::ZERO16;                                  // (RULE18) (RULE25)
                     roll = 1'b1;
                  end else begin
                     nx = c16 + fpw_pkg::ONE16;
                  end
               end else if (!s.dn[u]) begin
                  if (c16 >= p16) begin
                     ndn = 1'b1;                                              // (RULE19)
                     nx  = (p16 == fpw_pkg::ZERO16) ? fpw_pkg::ZERO16 : c16 - fpw_pkg::ONE16;
                  end else begin
                     nx = c16 + fpw_pkg::ONE16;
                  end
               end else if (c16 == fpw_pkg::ZERO16) begin
                  ndn  = 1'b0;                                                // (RULE19) (RULE25)
                  nx   = (p16 == fpw_pkg::ZERO16) ? fpw_pkg::ZERO16 : fpw_pkg::ONE16;
                  roll = 1'b1;
               end else begin
                  nx = c16 - fpw_pkg::ONE16;
               end
               n.dn[u] = ndn;
               n.out[u] = level(nx, p16, d16, mx,                             // (RULE5) (RULE6)
                                s.pol_cfg[fpw_pkg::POL_LSB + u], center, ndn); // (RULE20)
               if (joined) begin
                  n.cnt[u]  = nx[15:8];
                  n.cnt[lo] = nx[7:0];
               end else begin
                  n.cnt[u] = nx[7:0];
               end
               if (roll) begin
                  n.per_act[u]  = s.per_buf[u];                               // (RULE23)
                  n.dty_act[u]  = s.dty_buf[u];
                  n.per_act[lo] = s.per_buf[lo];
                  n.dty_act[lo] = s.dty_buf[lo];
               end
            end
         end
      end

      // software writes act last so they win over the counting above
      if (wr) begin
         case (idx)
            fpw_pkg::IDX_CLK:  n.clk_cfg = wd;
            fpw_pkg::IDX_POL:  n.pol_cfg = wd;
            fpw_pkg::IDX_EN:   n.en      = {4'h0, wd[3:0]};
            fpw_pkg::IDX_PRES: begin
               if (special_mode_flag) begin
                  n.pres = wd[6:0];                                           // (RULE10)
               end
            end
            fpw_pkg::IDX_SCAL0, fpw_pkg::IDX_SCAL1: begin
               n.scal[idx[1]] = wd;
               if (!(special_mode_flag && s.tst[fpw_pkg::SLD_BIT])) begin
                  n.scnt[idx[1]] = wd;                                        // (RULE11)
               end
            end
            fpw_pkg::IDX_CTL:  n.ctl  = wd;
            fpw_pkg::IDX_TST: begin
               if (special_mode_flag) begin
                  n.tst = wd & fpw_pkg::TST_MASK;
               end
            end
            fpw_pkg::IDX_PDAT: n.pdat = {4'h0, wd[3:0]};
            fpw_pkg::IDX_PDIR: n.pdir = {4'h0, wd[3:0]};
            default: begin
               if (idx[6:2] == fpw_pkg::IDX_CNT0[6:2]) begin
                  if (!(special_mode_flag && s.tst[fpw_pkg::CRD_BIT])) begin  // (RULE16)
                     n.cnt[idx[1:0]] = fpw_pkg::BYTE_ZERO;                    // (RULE15)
                     n.dn[idx[1:0]]  = 1'b0;
                  end
                  n.per_act[idx[1:0]] = s.per_buf[idx[1:0]];                  // (RULE15)
                  n.dty_act[idx[1:0]] = s.dty_buf[idx[1:0]];
               end else if (idx[6:2] == fpw_pkg::IDX_PER0[6:2]) begin
                  n.per_buf[idx[1:0]] = wd;
                  if (!s.en[idx[1:0]]) begin
                     n.per_act[idx[1:0]] = wd;                                // (RULE23)
                  end
               end else if (idx[6:2] == fpw_pkg::IDX_DTY0[6:2]) begin
                  n.dty_buf[idx[1:0]] = wd;
                  if (!s.en[idx[1:0]]) begin
                     n.dty_act[idx[1:0]] = wd;                                // (RULE23)
                  end
               end
            end
         endcase
      end

      // test bits exist only in special mode
      if (!special_mode_flag) begin
         n.tst = fpw_pkg::BYTE_ZERO;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         s <= '0;                                                             // (RULE26)
      end else begin
         s <= n;
      end
   end

   assign prdata  = s.prdata;
   assign pready  = psel & penable;
   assign pslverr = psel & penable & s.pslverr;

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         pwm_pin_oe[i]  = s.en[i] | s.pdir[i];                                // (RULE7)
         pwm_pin_out[i] = (s.en[i] & s.live[i]) ? s.out[i] : s.pdat[i];       // (RULE9)
      end
   end

endmodule // fpw_top
